/* hw/pprt_pkg.sv */
package pprt_pkg;

   // ==============================================================
   // Register byte offsets
   localparam logic [5:0] OFF_DATA_LATCH = 6'h00;
   localparam logic [5:0] OFF_PIN_SENSE  = 6'h04;
   localparam logic [5:0] OFF_DIRECTION  = 6'h08;
   localparam logic [5:0] OFF_RED_DRIVE  = 6'h0c;
   localparam logic [5:0] OFF_PULL_EN    = 6'h10;
   localparam logic [5:0] OFF_PULL_POL   = 6'h14;
   localparam logic [5:0] OFF_PWM7_ROUTE = 6'h18;
   localparam logic [5:0] OFF_LOW_ROUTE  = 6'h1c;

   // ==============================================================
   // Reset values and field positions
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [7:0] RST_PULL_EN   = 8'hff;
   localparam int         CH6_ROUTE_LSB = 6;
   localparam int         CH5_ROUTE_BIT = 5;
   localparam int         CH4_ROUTE_BIT = 4;

   // ==============================================================
   // Route codes and bus answers
   localparam logic [1:0] ROUTE_P_A   = 2'h0;
   localparam logic [1:0] ROUTE_S     = 2'h1;
   localparam logic [1:0] ROUTE_V     = 2'h2;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==============================================================
   // Carriers
   typedef struct packed {
      logic       lcd_en;
      logic       shutdown_en;
      logic [7:0] chan_en;
      logic [7:0] pwm;
   } pprt_ovr_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] ie;
      logic [7:0] reduced;
      logic [7:0] pull_en;
      logic [7:0] pull_dn;
   } pprt_pad_t;

   typedef struct packed {
      logic [7:0] s_sel;
      logic [7:0] s_val;
      logic [3:0] v_sel;
      logic [3:0] v_val;
   } pprt_alt_t;

endpackage : pprt_pkg

/* hw/pprt_port.sv */
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps

module pprt_port (
   // Clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // AXI4-Lite write
   input  wire logic [5:0]          awaddr,
   input  wire logic [2:0]          awprot,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   // AXI4-Lite read
   input  wire logic [5:0]          araddr,
   input  wire logic [2:0]          arprot,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   // PWM and LCD side
   input  wire pprt_pkg::pprt_ovr_t ovr,
   // Pads
   input  wire logic [7:0]          pin_in,
   output pprt_pkg::pprt_pad_t      pad,
   output pprt_pkg::pprt_alt_t      alt,
   output logic [7:0]               edge_evt
);

   // ==============================================================
   // Registers
   logic [7:0] latch_reg;
   logic [7:0] dir_reg;
   logic [7:0] red_reg;
   logic [7:0] pull_en_reg;
   logic [7:0] pol_reg;
   logic [1:0] r7_reg;
   logic [7:0] rlo_reg;
   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   logic [7:0] prev_reg;
   logic [7:0] edge_reg;
   logic       bvalid_reg;
   logic [1:0] bresp_reg;
   logic       rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;

   // Code 00 and 11 both keep a channel on Port P
   function automatic logic on_port_p(input logic [1:0] code);
      on_port_p = (code == pprt_pkg::ROUTE_P_A) || (code == 2'h3);
   endfunction : on_port_p

   function automatic logic mapped(input logic [5:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= pprt_pkg::OFF_LOW_ROUTE);
   endfunction : mapped

   // ==============================================================
   // Routing decode
   wire [1:0] r6_code = rlo_reg[pprt_pkg::CH6_ROUTE_LSB +: 2];
   wire [7:0] on_p;
   assign on_p[7]   = on_port_p(r7_reg);
   assign on_p[6]   = on_port_p(r6_code);
   assign on_p[5:4] = ~rlo_reg[5:4];
   assign on_p[3:0] = ~rlo_reg[3:0];

   assign alt.s_sel = {rlo_reg[3:0], 2'h0,
                       r7_reg == pprt_pkg::ROUTE_S,
                       r6_code == pprt_pkg::ROUTE_S};
   assign alt.s_val = {ovr.pwm[3:0], 2'h0, ovr.pwm[7], ovr.pwm[6]};
   assign alt.v_sel = {r7_reg == pprt_pkg::ROUTE_V,
                       r6_code == pprt_pkg::ROUTE_V,
                       rlo_reg[pprt_pkg::CH5_ROUTE_BIT],
                       rlo_reg[pprt_pkg::CH4_ROUTE_BIT]};
   assign alt.v_val = ovr.pwm[7:4];

   // ==============================================================
   // Pin direction and pad control
   // LCD wins, then shutdown on line 7, then PWM, then the direction bit
   wire [7:0] pwm_own = ovr.chan_en & on_p;
   wire [7:0] force_in = {ovr.shutdown_en, 7'h00};
   wire [7:0] oe_eff = ovr.lcd_en ? 8'h00 :
                       ((dir_reg | pwm_own) & ~force_in);
   wire [7:0] in_use = ovr.lcd_en ? 8'h00 : ~oe_eff;

   assign pad.oe      = oe_eff;
   assign pad.ie      = ovr.lcd_en ? 8'h00 : 8'hff;
   assign pad.out     = (pwm_own & ovr.pwm) | (~pwm_own & latch_reg);
   assign pad.reduced = red_reg & oe_eff;
   assign pad.pull_en = pull_en_reg & in_use;
   assign pad.pull_dn = pol_reg;

   // ==============================================================
   // Input synchroniser and edge detect
   wire [7:0] edge_next = (pol_reg & sync2_reg & ~prev_reg) |
                          (~pol_reg & ~sync2_reg & prev_reg);
   // Two stages make the sense value lag pin or direction changes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= pprt_pkg::RST_ZERO;
         sync2_reg <= pprt_pkg::RST_ZERO;
         prev_reg  <= pprt_pkg::RST_ZERO;
         edge_reg  <= pprt_pkg::RST_ZERO;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
         edge_reg  <= edge_next;
      end
   end

   assign edge_evt = edge_reg;

   // ==============================================================
   // AXI4-Lite write path
   // Address and data are taken together; a lone channel waits
   wire wr_fire = awvalid && wvalid && !bvalid_reg;
   wire wr_ok   = mapped(awaddr);
   wire wr_b0   = wr_fire && wstrb[0];
   assign awready = wr_fire;
   assign wready  = wr_fire;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;

   wire we_latch = wr_b0 && (awaddr == pprt_pkg::OFF_DATA_LATCH);
   wire we_dir   = wr_b0 && (awaddr == pprt_pkg::OFF_DIRECTION);
   wire we_red   = wr_b0 && (awaddr == pprt_pkg::OFF_RED_DRIVE);
   wire we_pull  = wr_b0 && (awaddr == pprt_pkg::OFF_PULL_EN);
   wire we_pol   = wr_b0 && (awaddr == pprt_pkg::OFF_PULL_POL);
   wire we_r7    = wr_b0 && (awaddr == pprt_pkg::OFF_PWM7_ROUTE);
   wire we_rlo   = wr_b0 && (awaddr == pprt_pkg::OFF_LOW_ROUTE);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_reg   <= pprt_pkg::RST_ZERO;
         dir_reg     <= pprt_pkg::RST_ZERO;
         red_reg     <= pprt_pkg::RST_ZERO;
         pull_en_reg <= pprt_pkg::RST_PULL_EN;
         pol_reg     <= pprt_pkg::RST_ZERO;
         r7_reg      <= pprt_pkg::ROUTE_P_A;
         rlo_reg     <= pprt_pkg::RST_ZERO;
      end else begin
         if (we_latch) latch_reg <= wdata[7:0];
         // Only software moves the direction bits
         if (we_dir) dir_reg <= wdata[7:0];
         if (we_red) red_reg <= wdata[7:0];
         if (we_pull) pull_en_reg <= wdata[7:0];
         if (we_pol) pol_reg <= wdata[7:0];
         if (we_r7) r7_reg <= wdata[1:0];
         if (we_rlo) rlo_reg <= wdata[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= pprt_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_ok ? pprt_pkg::RESP_OKAY : pprt_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ==============================================================
   // AXI4-Lite read path
   wire [7:0] data_rd = (dir_reg & latch_reg) | (~dir_reg & sync2_reg);
   wire       rd_fire = arvalid && !rvalid_reg;
   assign arready = !rvalid_reg;
   assign rvalid  = rvalid_reg;
   assign rresp   = rresp_reg;
   assign rdata   = rdata_reg;

   logic [7:0] rd_mux;
   always_comb begin
      case (araddr)
         pprt_pkg::OFF_DATA_LATCH: rd_mux = data_rd;
         pprt_pkg::OFF_PIN_SENSE:  rd_mux = sync2_reg;
         pprt_pkg::OFF_DIRECTION:  rd_mux = dir_reg;
         pprt_pkg::OFF_RED_DRIVE:  rd_mux = red_reg;
         pprt_pkg::OFF_PULL_EN:    rd_mux = pull_en_reg;
         pprt_pkg::OFF_PULL_POL:   rd_mux = pol_reg;
         pprt_pkg::OFF_PWM7_ROUTE: rd_mux = {6'h00, r7_reg};
         pprt_pkg::OFF_LOW_ROUTE:  rd_mux = rlo_reg;
         default:                  rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= pprt_pkg::RESP_OKAY;
         rdata_reg  <= 32'h0000_0000;
      end else if (rd_fire) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= mapped(araddr) ? pprt_pkg::RESP_OKAY : pprt_pkg::RESP_SLVERR;
         rdata_reg  <= {24'h00_0000, rd_mux};
      end else if (rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ==============================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_lcd_pad_off: assert property (
      ovr.lcd_en |-> (pad.oe == 8'h00) && (pad.ie == 8'h00))
      else $error("LCD enable left a pad active");

   a_pwm7_forces_out: assert property (
      (!ovr.lcd_en && !ovr.shutdown_en && ovr.chan_en[7] && on_p[7]) |-> pad.oe[7])
      else $error("PWM7 did not force line 7 output");

   a_shutdown_forces_in: assert property (
      (ovr.shutdown_en) |-> !pad.oe[7])
      else $error("Shutdown did not force line 7 input");

   a_pwm0_forces_out: assert property (
      (!ovr.lcd_en && ovr.chan_en[0] && !rlo_reg[0]) |-> pad.oe[0])
      else $error("PWM0 did not force line 0 output");

   a_dir_kept: assert property (
      !we_dir |=> $stable(dir_reg))
      else $error("Direction bits changed without a write");

   a_dir_plain: assert property (
      (!ovr.lcd_en && !ovr.shutdown_en && ovr.chan_en == 8'h00) |-> pad.oe == dir_reg)
      else $error("Pad direction differs from direction bits");

   a_sense_lag: assert property (
      (aresetn && $stable(pin_in)) [*3] |-> sync2_reg == pin_in)
      else $error("Sense value lags more than two clocks");

   a_reduced_out: assert property (
      (pad.reduced & ~pad.oe) == 8'h00)
      else $error("Reduced drive on an input line");

   a_pull_input: assert property (
      (pad.pull_en & pad.oe) == 8'h00)
      else $error("Pull device on an output line");

   a_pull_reset: assert property (
      $rose(aresetn) |-> pull_en_reg == pprt_pkg::RST_PULL_EN)
      else $error("Pull enables not set after reset");

   a_rise_edge: assert property (
      (pol_reg[0] && sync2_reg[0] && !prev_reg[0]) |=> edge_evt[0])
      else $error("Rising edge event missed on line 0");

   a_write_answer: assert property (
      wr_fire |=> bvalid && (bresp == ($past(wr_ok) ? pprt_pkg::RESP_OKAY
                                                    : pprt_pkg::RESP_SLVERR)))
      else $error("Write answer missing or wrong");

   a_pwm_low_out: assert property (
      !ovr.lcd_en |-> ((pad.oe[6:0] & pwm_own[6:0]) == pwm_own[6:0]))
      else $error("Enabled low PWM channel left its line undriven");

   a_pwm7_value: assert property (
      (!ovr.lcd_en && pwm_own[7]) |-> pad.out[7] == ovr.pwm[7])
      else $error("Line 7 does not carry PWM7");

   a_route7_s: assert property (
      (r7_reg == pprt_pkg::ROUTE_S) |-> alt.s_sel[1] && !on_p[7] && !alt.v_sel[3])
      else $error("PWM7 not moved to Port S line 1");

   a_route7_v: assert property (
      (r7_reg == pprt_pkg::ROUTE_V) |-> alt.v_sel[3] && !on_p[7] && !alt.s_sel[1])
      else $error("PWM7 not moved to Port V line 3");

   a_route6_home: assert property (
      (r6_code == 2'h3) |-> on_p[6] && !alt.s_sel[0] && !alt.v_sel[2])
      else $error("PWM6 code 11 left Port P line 6");

   a_route_low_s: assert property (
      rlo_reg[3] |-> alt.s_sel[7] && (alt.s_val[7] == ovr.pwm[3]) && !on_p[3])
      else $error("PWM3 not moved to Port S line 7");

   a_route_low_v: assert property (
      rlo_reg[5] |-> alt.v_sel[1] && (alt.v_val[1] == ovr.pwm[5]) && !on_p[5])
      else $error("PWM5 not moved to Port V line 1");

   a_routed_away: assert property (
      (!ovr.lcd_en && rlo_reg[0]) |-> pad.oe[0] == dir_reg[0])
      else $error("Rerouted PWM0 still overrides line 0");

   a_pull_polarity: assert property (
      ((pad.pull_dn ^ pol_reg) & pad.pull_en) == 8'h00)
      else $error("Active pull has the wrong polarity");

   a_lcd_no_pull: assert property (
      ovr.lcd_en |-> pad.pull_en == 8'h00)
      else $error("Pull device active under LCD enable");

   a_reduced_plain: assert property (
      (!ovr.lcd_en && !ovr.shutdown_en && ovr.chan_en == 8'h00) |-> pad.reduced == (red_reg & dir_reg))
      else $error("Reduced drive differs from its bits");

   a_fall_edge: assert property (
      (!pol_reg[7] && !sync2_reg[7] && prev_reg[7]) |=> edge_evt[7])
      else $error("Falling edge event missed on line 7");

   a_edge_pulse: assert property (
      edge_evt[0] |=> !edge_evt[0])
      else $error("Edge event stood longer than one cycle");

   a_read_error: assert property (
      (rd_fire && !mapped(araddr)) |=> rvalid && (rresp == pprt_pkg::RESP_SLVERR) && (rdata == 32'h0000_0000))
      else $error("Unmapped read not refused");

   a_sense_read: assert property (
      (rd_fire && araddr == pprt_pkg::OFF_PIN_SENSE) |=> rdata == {24'h00_0000, $past(sync2_reg)})
      else $error("Sense read differs from synchronised pins");

endmodule : pprt_port

/* bench/pprt_pads.sv */
`timescale 1ns/1ps

// ==============================================================
// Pad model: block drivers, pulls and an outside source
module pprt_pads (
   // Clock
   input  wire logic                aclk,
   // Block pads
   input  wire pprt_pkg::pprt_pad_t pad,
   // Outside source
   input  wire logic [7:0]          ext_en,
   input  wire logic [7:0]          ext_val,
   // Pin levels
   output logic [7:0]               pin_in
);
   logic [7:0] flip_reg = 8'h55;

   // Floating lines toggle so a stale level never passes for a driven one
   always @(posedge aclk) flip_reg <= ~flip_reg;

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad.oe[i]) pin_in[i] = pad.out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pad.pull_en[i]) pin_in[i] = ~pad.pull_dn[i];
         else pin_in[i] = flip_reg[i];
      end
   end
endmodule : pprt_pads

/* bench/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end

// ==============================================================
// Bench top
module tb;
   logic                aclk = 0, aresetn = 0, clr = 0;
   logic [5:0]          awaddr = 0, araddr = 0;
   logic                awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0]         wdata = 0, rdata;
   logic                awready, wready, bvalid, arready, rvalid;
   logic [1:0]          bresp, rresp, bx, bq[$];
   pprt_pkg::pprt_ovr_t ovr = '0;
   pprt_pkg::pprt_pad_t pad;
   pprt_pkg::pprt_alt_t alt;
   logic [7:0]          pin_in, edge_evt, ext_en = 0, ext_val = 0, evt_acc = 0;
   logic [7:0]          d, w, r, pe, pol, e, p, l, v, so, vo;
   logic [33:0]         rx, rq[$];
   int                  fails = 0, checks = 0, seed = 53;

   initial begin
      forever #20 aclk = ~aclk;
   end

   pprt_port pprt_port_inst (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
      .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .ovr, .pin_in,
      .pad, .alt, .edge_evt);
   pprt_pads pprt_pads_inst (.aclk, .pad, .ext_en, .ext_val, .pin_in);

   // ==============================================================
   // Watcher: oldest note against each answer
   always @(posedge aclk) begin
      evt_acc <= clr ? 8'h00 : evt_acc | edge_evt;
      if (rvalid && rready && rq.size() > 0) begin
         rx = rq.pop_front();
         `CHK("read", rx, {rresp, rdata})
      end
      if (bvalid && bready && bq.size() > 0) begin
         bx = bq.pop_front();
         `CHK("bresp", bx, bresp)
      end
   end

   task automatic tally_and_finish();
      if (fails == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   // Bounded wait for one handshake
   task automatic await(input int k);
      int n;
      n = 0;
      do begin
         @(negedge aclk);
         n++;
         if (n > 50) begin
            fails++;
            tally_and_finish();
         end
      end while (!(k == 0 ? awready && wready : k == 1 ? bvalid : k == 2 ? arready : rvalid));
   endtask : await

   task automatic wr(input logic [5:0] a, input logic [7:0] x, input logic [1:0] rs);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'h0, x};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      bq.push_back(rs);
      await(0);
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      await(1);
      @(posedge aclk);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [7:0] x, input logic [1:0] rs);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      rq.push_back({rs, 24'h0, x});
      await(2);
      @(posedge aclk);
      arvalid <= 1'b0;
      await(3);
      @(posedge aclk);
      rready <= 1'b0;
   endtask : rd

   // ==============================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 8; i++) rd(6'(4 * i), (i < 2 || i == 4) ? 8'hff : 8'h00, 2'h0);
      rd(6'h20, 8'h00, pprt_pkg::RESP_SLVERR);
      wr(6'h20, 8'h5a, pprt_pkg::RESP_SLVERR);
      for (int i = 0; i < 12; i++) begin
         v = 8'($random(seed));
         wr(6'(8 + 4 * (i % 6)), v, 2'h0);
         rd(6'(8 + 4 * (i % 6)), (i % 6 == 4) ? v & 8'h03 : v, 2'h0);
      end
      // Direction, drive strength and pulls
      {w, d, r, pe, pol, e} = 48'({$random(seed), $random(seed)});
      ext_en  <= 8'hff;
      ext_val <= e;
      wr(pprt_pkg::OFF_DATA_LATCH, w, 2'h0);
      wr(pprt_pkg::OFF_DIRECTION, d, 2'h0);
      wr(pprt_pkg::OFF_RED_DRIVE, r, 2'h0);
      wr(pprt_pkg::OFF_PULL_EN, pe, 2'h0);
      wr(pprt_pkg::OFF_PULL_POL, pol, 2'h0);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      `CHK("oe", d, pad.oe)
      `CHK("out", w, pad.out)
      `CHK("reduced", r & d, pad.reduced & pad.oe)
      `CHK("pull_en", pe & ~d, pad.pull_en & ~pad.oe)
      `CHK("pull_dn", pol, pad.pull_dn)
      `CHK("ie", 8'hff, pad.ie)
      rd(pprt_pkg::OFF_DATA_LATCH, (w & d) | (e & ~d), 2'h0);
      rd(pprt_pkg::OFF_PIN_SENSE, (w & d) | (e & ~d), 2'h0);
      // Overrides keep the stored direction intact
      wr(pprt_pkg::OFF_PWM7_ROUTE, 8'h00, 2'h0);
      wr(pprt_pkg::OFF_LOW_ROUTE, 8'h00, 2'h0);
      p = 8'($random(seed));
      ovr <= '{lcd_en: 1'b0, shutdown_en: 1'b0, chan_en: 8'hff, pwm: p};
      @(negedge aclk);
      `CHK("pwm oe", 8'hff, pad.oe)
      `CHK("pwm out", p, pad.out)
      rd(pprt_pkg::OFF_DIRECTION, d, 2'h0);
      ovr.shutdown_en <= 1'b1;
      @(negedge aclk);
      `CHK("shutdown oe", 8'h7f, pad.oe)
      @(posedge aclk);
      ovr.lcd_en <= 1'b1;
      @(negedge aclk);
      `CHK("lcd oe ie pull", 24'h00_0000, {pad.oe, pad.ie, pad.pull_en})
      @(posedge aclk);
      ovr.lcd_en <= 1'b0;
      ovr.shutdown_en <= 1'b0;
      // Routing of every channel, each code of channel 7
      wr(pprt_pkg::OFF_DIRECTION, 8'h00, 2'h0);
      for (int c = 0; c < 4; c++) begin
         l = 8'($random(seed));
         wr(pprt_pkg::OFF_PWM7_ROUTE, 8'(c), 2'h0);
         wr(pprt_pkg::OFF_LOW_ROUTE, l, 2'h0);
         @(negedge aclk);
         so = {l[3:0], 2'b00, c == 1, l[7:6] == 2'h1};
         vo = {4'h0, c == 2, l[7:6] == 2'h2, l[5], l[4]};
         `CHK("route oe", {c == 0 || c == 3, l[7] == l[6], ~l[5:0]}, pad.oe)
         `CHK("s_sel", so, alt.s_sel)
         `CHK("v_sel", vo[3:0], alt.v_sel)
         `CHK("s_val", so & {p[3:0], 2'b00, p[7:6]}, alt.s_val & alt.s_sel)
         `CHK("v_val", vo[3:0] & p[7:4], alt.v_val & alt.v_sel)
      end
      // Edge polarity: low lines rise-active, high lines fall-active
      @(posedge aclk);
      ovr <= '0;
      ext_val <= 8'h00;
      wr(pprt_pkg::OFF_PULL_POL, 8'h0f, 2'h0);
      repeat (6) @(posedge aclk);
      for (int k = 0; k < 2; k++) begin
         clr     <= 1'b1;
         ext_val <= ~ext_val;
         @(posedge aclk);
         clr <= 1'b0;
         repeat (7) @(posedge aclk);
         `CHK("edge_evt", (k == 0) ? 8'h0f : 8'hf0, evt_acc)
      end
      tally_and_finish();
   end
endmodule : tb
